// ### verilog/exec_pkg.sv
package exec_pkg;

  localparam int INSTR_W = 14;
  localparam int PC_W    = 13;
  localparam int DATA_W  = 8;
  localparam int FADDR_W = 7;
  localparam int SP_W    = 3;
  localparam int STACK_N = 8;

  localparam logic [INSTR_W-1:0] MASK_COPY   = 14'h3f00;
  localparam logic [INSTR_W-1:0] CODE_COPY   = 14'h0800;
  localparam logic [INSTR_W-1:0] MASK_STORE  = 14'h3f80;
  localparam logic [INSTR_W-1:0] CODE_STORE  = 14'h0080;
  localparam logic [INSTR_W-1:0] MASK_CONST  = 14'h3c00;
  localparam logic [INSTR_W-1:0] CODE_LOADK  = 14'h3000;
  localparam logic [INSTR_W-1:0] CODE_RETK   = 14'h3400;
  localparam logic [INSTR_W-1:0] MASK_FULL   = 14'h3fff;
  localparam logic [INSTR_W-1:0] CODE_RETIRQ = 14'h0009;
  localparam logic [INSTR_W-1:0] CODE_RETSUB = 14'h0008;
  localparam logic [INSTR_W-1:0] MASK_NOP    = 14'h3f9f;
  localparam logic [INSTR_W-1:0] CODE_NOP    = 14'h0000;
  localparam int                 DEST_BIT    = 7;

  localparam logic [7:0] REG_ACC    = 8'h00;
  localparam logic [7:0] REG_IRQCTL = 8'h04;
  localparam logic [7:0] REG_FLAGS  = 8'h08;
  localparam logic [7:0] REG_PC     = 8'h0c;
  localparam logic [7:0] REG_STACK  = 8'h10;

  localparam int GATE_BIT  = 7;
  localparam int ZERO_BIT  = 0;
  localparam int BUSY_BIT  = 1;
  localparam int BADOP_BIT = 2;

  localparam logic [DATA_W-1:0] RST_ACC    = 8'h00;
  localparam logic [DATA_W-1:0] RST_IRQCTL = 8'h00;
  localparam logic [PC_W-1:0]   RST_PC     = 13'h0000;
  localparam logic [PC_W-1:0]   PC_STEP    = 13'h0001;
  localparam logic [SP_W-1:0]   SP_STEP    = 3'h1;

  typedef enum logic [6:0] {
    OP_NOP    = 7'h01,
    OP_COPY   = 7'h02,
    OP_STORE  = 7'h04,
    OP_LOADK  = 7'h08,
    OP_RETIRQ = 7'h10,
    OP_RETK   = 7'h20,
    OP_RETSUB = 7'h40
  } op_t;

  typedef enum logic [1:0] {
    ST_FETCH = 2'b01,
    ST_FLUSH = 2'b10
  } state_t;

  typedef struct packed {
    logic               valid;
    op_t                op;
    logic               dest;
    logic [FADDR_W-1:0] faddr;
    logic [DATA_W-1:0]  k;
  } exec_t;

endpackage : exec_pkg

// ### verilog/file_memory.sv
`timescale 1ns/100ps
// Write-first: a read of the address being written returns the new byte, which
// removes the hazard of a store followed at once by a copy of the same register
module file_memory (
  input  wire logic                           clk,
  input  wire logic                           rst_n,
  input  wire logic [exec_pkg::FADDR_W-1:0]   rdAddr,
  output logic      [exec_pkg::DATA_W-1:0]    rdData,
  input  wire logic                           wrEn,
  input  wire logic [exec_pkg::FADDR_W-1:0]   wrAddr,
  input  wire logic [exec_pkg::DATA_W-1:0]    wrData
);

  logic [exec_pkg::DATA_W-1:0] mem [2**exec_pkg::FADDR_W];
  logic [exec_pkg::DATA_W-1:0] next_rdData;

  always_comb
  begin
    if (wrEn && (wrAddr == rdAddr))
      next_rdData = wrData;
    else
      next_rdData = mem[rdAddr];
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      rdData <= exec_pkg::RST_ACC;
    else
      rdData <= next_rdData;
  end

  always_ff @(posedge clk)
  begin
    if (wrEn)
      mem[wrAddr] <= wrData;
  end

endmodule : file_memory

// ### verilog/move_and_return_instruction_exec.sv
// Design decisions made here: register access over APB and the register offsets.
`timescale 1ns/100ps
module move_and_return_instruction_exec (
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  input  wire logic [7:0]                    paddr,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire logic [exec_pkg::INSTR_W-1:0]  instrWord,
  input  wire logic                          instrValid,
  output logic                               instrReady,
  output logic      [exec_pkg::PC_W-1:0]     fetchAddr,
  output logic      [exec_pkg::DATA_W-1:0]   accumulator,
  output logic                               zeroFlag,
  output logic                               masterIrqGate
);

  exec_pkg::state_t             state;
  exec_pkg::state_t             next_state;
  exec_pkg::exec_t              exec;
  exec_pkg::exec_t              next_exec;
  logic                         next_instrReady;
  logic [exec_pkg::PC_W-1:0]    next_fetchAddr;
  logic [exec_pkg::DATA_W-1:0]  next_accumulator;
  logic                         next_zeroFlag;
  logic [exec_pkg::DATA_W-1:0]  irqCtl;
  logic [exec_pkg::DATA_W-1:0]  next_irqCtl;
  logic                         badOp;
  logic                         next_badOp;
  logic [exec_pkg::PC_W-1:0]    stackMem [exec_pkg::STACK_N];
  logic [exec_pkg::SP_W-1:0]    sp;
  logic [exec_pkg::SP_W-1:0]    next_sp;
  logic                         stackWrEn;
  logic [exec_pkg::SP_W-1:0]    stackWrIdx;
  logic [exec_pkg::PC_W-1:0]    stackTop;
  logic [31:0]                  next_prdata;
  logic                         next_pready;
  logic                         next_pslverr;
  logic                         accept;
  logic                         busWr;
  logic                         isReturn;
  logic                         doPop;
  logic                         ramWrEn;
  logic [exec_pkg::DATA_W-1:0]  ramWrData;
  logic [exec_pkg::DATA_W-1:0]  ramRdData;
  logic                         knownOp;
  logic                         mapped;

  assign masterIrqGate = irqCtl[exec_pkg::GATE_BIT];
  assign accept        = instrReady && instrValid;
  assign busWr         = psel && penable && pready && pwrite;
  assign stackTop      = stackMem[sp - exec_pkg::SP_STEP];
  assign doPop         = exec.valid && ((exec.op == exec_pkg::OP_RETIRQ) ||
                         (exec.op == exec_pkg::OP_RETK) || (exec.op == exec_pkg::OP_RETSUB));

  // Decode of the word on the fetch port
  always_comb
  begin
    next_exec       = '0;
    next_exec.op    = exec_pkg::OP_NOP;
    knownOp         = 1'b1;
    next_exec.valid = accept;
    next_exec.dest  = instrWord[exec_pkg::DEST_BIT];
    next_exec.faddr = instrWord[exec_pkg::FADDR_W-1:0];
    next_exec.k     = instrWord[exec_pkg::DATA_W-1:0];
    if ((instrWord & exec_pkg::MASK_COPY) == exec_pkg::CODE_COPY)
      next_exec.op = exec_pkg::OP_COPY;
    else if ((instrWord & exec_pkg::MASK_STORE) == exec_pkg::CODE_STORE)
      next_exec.op = exec_pkg::OP_STORE;
    // Don't-care bits of constant forms are not looked at
    else if ((instrWord & exec_pkg::MASK_CONST) == exec_pkg::CODE_LOADK)
      next_exec.op = exec_pkg::OP_LOADK;
    else if ((instrWord & exec_pkg::MASK_CONST) == exec_pkg::CODE_RETK)
      next_exec.op = exec_pkg::OP_RETK;
    else if ((instrWord & exec_pkg::MASK_FULL) == exec_pkg::CODE_RETIRQ)
      next_exec.op = exec_pkg::OP_RETIRQ;
    else if ((instrWord & exec_pkg::MASK_FULL) == exec_pkg::CODE_RETSUB)
      next_exec.op = exec_pkg::OP_RETSUB;
    else if ((instrWord & exec_pkg::MASK_NOP) == exec_pkg::CODE_NOP)
      next_exec.op = exec_pkg::OP_NOP;
    else
      knownOp = 1'b0;
    isReturn = (next_exec.op == exec_pkg::OP_RETIRQ) || (next_exec.op == exec_pkg::OP_RETK) ||
               (next_exec.op == exec_pkg::OP_RETSUB);
  end

  // Sequencing: a return blocks fetch for its second cycle
  always_comb
  begin
    next_state     = state;
    next_fetchAddr = fetchAddr;
    case (state)
      exec_pkg::ST_FETCH:
      begin
        if (accept)
        begin
          next_fetchAddr = fetchAddr + exec_pkg::PC_STEP;
          if (isReturn)
            next_state = exec_pkg::ST_FLUSH;
        end
        else if (busWr && (paddr == exec_pkg::REG_PC))
          next_fetchAddr = pwdata[exec_pkg::PC_W-1:0];
      end
      exec_pkg::ST_FLUSH:
      begin
        next_state = exec_pkg::ST_FETCH;
        if (doPop)
          next_fetchAddr = stackTop;
      end
      default:
        next_state = exec_pkg::ST_FETCH;
    endcase
    next_instrReady = (next_state == exec_pkg::ST_FETCH);
  end

  // Execute stage: file data arrives from the registered read one cycle after accept
  always_comb
  begin
    next_accumulator = accumulator;
    next_zeroFlag    = zeroFlag;
    next_irqCtl      = irqCtl;
    next_badOp       = badOp;
    ramWrEn          = 1'b0;
    ramWrData        = accumulator;
    if (busWr && (paddr == exec_pkg::REG_ACC))
      next_accumulator = pwdata[exec_pkg::DATA_W-1:0];
    if (busWr && (paddr == exec_pkg::REG_IRQCTL))
      next_irqCtl = pwdata[exec_pkg::DATA_W-1:0];
    if (busWr && (paddr == exec_pkg::REG_FLAGS))
    begin
      next_zeroFlag = pwdata[exec_pkg::ZERO_BIT];
      if (pwdata[exec_pkg::BADOP_BIT])
        next_badOp = 1'b0;
    end
    // Unknown words run as no operation but leave a sticky mark; setting wins
    if (accept && !knownOp)
      next_badOp = 1'b1;
    if (exec.valid)
    begin
      case (exec.op)
        exec_pkg::OP_COPY:
        begin
          next_zeroFlag = (ramRdData == '0);
          if (exec.dest)
          begin
            ramWrEn   = 1'b1;
            ramWrData = ramRdData;
          end
          else
            next_accumulator = ramRdData;
        end
        exec_pkg::OP_STORE:
          ramWrEn = 1'b1;
        exec_pkg::OP_LOADK:
          next_accumulator = exec.k;
        exec_pkg::OP_RETK:
          next_accumulator = exec.k;
        exec_pkg::OP_RETIRQ:
          next_irqCtl[exec_pkg::GATE_BIT] = 1'b1;
        default:
          next_accumulator = next_accumulator;
      endcase
    end
  end

  // Stack: a pop and a bus push in one cycle replace the top entry
  always_comb
  begin
    next_sp    = sp;
    stackWrEn  = busWr && (paddr == exec_pkg::REG_STACK);
    stackWrIdx = sp;
    if (doPop && stackWrEn)
      stackWrIdx = sp - exec_pkg::SP_STEP;
    else if (doPop)
      next_sp = sp - exec_pkg::SP_STEP;
    else if (stackWrEn)
      next_sp = sp + exec_pkg::SP_STEP;
  end

  // APB slave: read data captured in the setup cycle, zero wait states
  always_comb
  begin
    mapped       = 1'b1;
    next_prdata  = '0;
    case (paddr)
      exec_pkg::REG_ACC:    next_prdata[exec_pkg::DATA_W-1:0] = accumulator;
      exec_pkg::REG_IRQCTL: next_prdata[exec_pkg::DATA_W-1:0] = irqCtl;
      exec_pkg::REG_FLAGS:
      begin
        next_prdata[exec_pkg::ZERO_BIT]  = zeroFlag;
        next_prdata[exec_pkg::BUSY_BIT]  = exec.valid || (state != exec_pkg::ST_FETCH);
        next_prdata[exec_pkg::BADOP_BIT] = badOp;
      end
      exec_pkg::REG_PC:     next_prdata[exec_pkg::PC_W-1:0] = fetchAddr;
      exec_pkg::REG_STACK:  next_prdata[exec_pkg::PC_W-1:0] = stackTop;
      default:              mapped = 1'b0;
    endcase
    next_pready  = psel && !penable;
    next_pslverr = psel && !penable && !mapped;
    if (!(psel && !penable))
      next_prdata = prdata;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state       <= exec_pkg::ST_FETCH;
      exec        <= '0;
      instrReady  <= 1'b1;
      fetchAddr   <= exec_pkg::RST_PC;
      accumulator <= exec_pkg::RST_ACC;
      zeroFlag    <= 1'b0;
      irqCtl      <= exec_pkg::RST_IRQCTL;
      badOp       <= 1'b0;
      sp          <= '0;
      prdata      <= '0;
      pready      <= 1'b0;
      pslverr     <= 1'b0;
    end
    else
    begin
      state       <= next_state;
      exec        <= next_exec;
      instrReady  <= next_instrReady;
      fetchAddr   <= next_fetchAddr;
      accumulator <= next_accumulator;
      zeroFlag    <= next_zeroFlag;
      irqCtl      <= next_irqCtl;
      badOp       <= next_badOp;
      sp          <= next_sp;
      prdata      <= next_prdata;
      pready      <= next_pready;
      pslverr     <= next_pslverr;
    end
  end

  always_ff @(posedge clk)
  begin
    if (stackWrEn)
      stackMem[stackWrIdx] <= pwdata[exec_pkg::PC_W-1:0];
  end

  file_memory u_file_memory (
    .clk    (clk),
    .rst_n  (rst_n),
    .rdAddr (instrWord[exec_pkg::FADDR_W-1:0]),
    .rdData (ramRdData),
    .wrEn   (ramWrEn),
    .wrAddr (exec.faddr),
    .wrData (ramWrData)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  logic busFlags;
  logic busAcc;
  assign busFlags = busWr && (paddr == exec_pkg::REG_FLAGS);
  assign busAcc   = busWr && (paddr == exec_pkg::REG_ACC);

  AST_COPY_TO_ACC: assert property (
    exec.valid && exec.op == exec_pkg::OP_COPY && !exec.dest |=> accumulator == $past(ramRdData))
    else $error("copy to accumulator lost the file value");
  AST_COPY_WRITEBACK: assert property (
    exec.valid && exec.op == exec_pkg::OP_COPY && exec.dest && !busAcc
    |-> ramWrEn && ramWrData == ramRdData ##1 accumulator == $past(accumulator))
    else $error("copy back to file changed data or accumulator");
  AST_COPY_ZERO: assert property (
    exec.valid && exec.op == exec_pkg::OP_COPY |=> zeroFlag == ($past(ramRdData) == '0))
    else $error("zero flag wrong after file copy");
  AST_ONE_CYCLE: assert property (
    accept && !isReturn |=> instrReady)
    else $error("single-cycle instruction stalled fetch");
  AST_STORE_NOFLAG: assert property (
    exec.valid && exec.op == exec_pkg::OP_STORE && !busFlags
    |-> ramWrEn && ramWrData == accumulator ##1 $stable(zeroFlag))
    else $error("store accumulator misbehaved");
  AST_LOADK: assert property (
    accept && next_exec.op == exec_pkg::OP_LOADK
    |=> ##1 accumulator == $past(instrWord[exec_pkg::DATA_W-1:0], 2))
    else $error("load constant value wrong");
  AST_RETIRQ_GATE: assert property (
    accept && next_exec.op == exec_pkg::OP_RETIRQ |=> ##1 masterIrqGate)
    else $error("irq gate not set on return from irq");
  AST_RET_PC: assert property (
    doPop |=> fetchAddr == $past(stackTop) &&
              sp == ($past(stackWrEn) ? $past(sp) : $past(sp) - exec_pkg::SP_STEP))
    else $error("return did not load stack top");
  AST_RETK_ACC: assert property (
    exec.valid && exec.op == exec_pkg::OP_RETK |=> accumulator == $past(exec.k))
    else $error("return with constant accumulator wrong");
  AST_TWO_CYCLE: assert property (
    accept && isReturn |=> !instrReady ##1 instrReady)
    else $error("return did not take two cycles");
  AST_NOP_QUIET: assert property (
    exec.valid && exec.op == exec_pkg::OP_NOP && !busAcc && !busFlags
    |-> !ramWrEn ##1 $stable(accumulator) && $stable(zeroFlag))
    else $error("no operation changed state");

  COV_COPY_BACK: cover property (exec.valid && exec.op == exec_pkg::OP_COPY && exec.dest);
  COV_RETIRQ:    cover property (exec.valid && exec.op == exec_pkg::OP_RETIRQ);
  COV_STORE_COPY: cover property (exec.valid && exec.op == exec_pkg::OP_STORE ##1
                                  exec.valid && exec.op == exec_pkg::OP_COPY);

endmodule : move_and_return_instruction_exec

// ### sim/program_rom.sv
`timescale 1ns/100ps
// Program store on the fetch side. It withholds the word at the stop address, so the
// bench can let the core run a chosen stretch of code and then park it there.
module program_rom (
  input  wire logic [exec_pkg::PC_W-1:0]    fetchAddr,
  input  wire logic [exec_pkg::PC_W-1:0]    stopAddr,
  output logic      [exec_pkg::INSTR_W-1:0] instrWord,
  output logic                              instrValid
);
  logic [exec_pkg::INSTR_W-1:0] mem [0:127];

  initial
  begin
    for (int i = 0; i < 128; i++)
      mem[i] = 14'h0000;
    mem[0]  = 14'h305a;
    mem[1]  = 14'h0085;
    mem[2]  = 14'h0805;
    mem[3]  = 14'h3000;
    mem[4]  = 14'h0885;
    mem[5]  = 14'h0086;
    mem[6]  = 14'h0806;
    mem[7]  = 14'h3077;
    mem[8]  = 14'h0000;
    mem[9]  = 14'h0060;
    mem[10] = 14'h0805;
    mem[11] = 14'h0008;
    mem[32] = 14'h3400;
    mem[48] = 14'h0009;
    // Not one of the decoded forms: must run as a no operation and mark the flag
    mem[64] = 14'h3800;
  end

  // A withheld word is shown inverted so a stale value cannot pass for a real one
  always_comb
  begin
    instrValid = (fetchAddr !== stopAddr);
    instrWord  = instrValid ? mem[fetchAddr[6:0]] : ~mem[fetchAddr[6:0]];
  end
endmodule : program_rom

// ### sim/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  logic                          clk;
  logic                          rst_n;
  logic [7:0]                    paddr;
  logic                          psel;
  logic                          penable;
  logic                          pwrite;
  logic [31:0]                   pwdata;
  logic [31:0]                   prdata;
  logic                          pready;
  logic                          pslverr;
  logic [exec_pkg::INSTR_W-1:0]  instrWord;
  logic                          instrValid;
  logic                          instrReady;
  logic [exec_pkg::PC_W-1:0]     fetchAddr;
  logic [exec_pkg::PC_W-1:0]     stopAddr;
  logic [exec_pkg::DATA_W-1:0]   accumulator;
  logic                          zeroFlag;
  logic                          masterIrqGate;
  logic [31:0]                   rdVal;
  logic                          errVal;
  int                            bad_count;
  int                            checks;
  int                            cycles;
  int                            lastCyc;
  int                            lowCyc;
  int stopTab [9] = '{2, 3, 5, 7, 10, 11, 32, 48, 64};
  int cycTab  [9] = '{2, 1, 2, 2, 3, 1, 2, 2, 2};
  int accTab  [9] = '{8'h5a, 8'h5a, 0, 0, 8'h77, 8'h5a, 8'h5a, 0, 0};
  int zeroTab [9] = '{1, 0, 0, 1, 1, 0, 0, 0, 0};
  int gateTab [9] = '{0, 0, 0, 0, 0, 0, 0, 0, 1};

  move_and_return_instruction_exec uut (
    .clk(clk), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .instrWord(instrWord), .instrValid(instrValid),
    .instrReady(instrReady), .fetchAddr(fetchAddr), .accumulator(accumulator),
    .zeroFlag(zeroFlag), .masterIrqGate(masterIrqGate)
  );

  program_rom rom (
    .fetchAddr(fetchAddr), .stopAddr(stopAddr), .instrWord(instrWord),
    .instrValid(instrValid)
  );

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task tally_and_finish;
    $display("Counts: %0d comparisons, %0d mismatches", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish

  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int w;
    w = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && w < 16)
    begin
      w++;
      @(posedge clk);
    end
    check(w < 16, 1'b1);
    rdVal = prdata;
    errVal = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Lets the core run from where it stands until it reaches stop, counting edges
  task run(input int stop);
    lastCyc = 0;
    lowCyc = 0;
    @(posedge clk);
    stopAddr <= stop[12:0];
    do
    begin
      @(posedge clk);
      lastCyc++;
      #1;
      if (instrReady !== 1'b1)
        lowCyc++;
    end
    while (fetchAddr !== stop[12:0] && lastCyc < 50);
    repeat (2) @(posedge clk);
    #1;
  endtask : run

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      bad_count++;
      tally_and_finish;
    end
  end

  initial
  begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    stopAddr = 13'h0000;
    cycles = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    for (int r = 0; r < 4; r++)
    begin
      apb(1'b0, 8'(r * 4), 32'h0000_0000);
      check(rdVal, 32'h0000_0000);
      check(errVal, 1'b0);
    end
    apb(1'b0, 8'h14, 32'h0000_0000);
    check(errVal, 1'b1);
    check(rdVal, 32'h0000_0000);
    apb(1'b1, exec_pkg::REG_IRQCTL, 32'h0000_0080);
    apb(1'b0, exec_pkg::REG_IRQCTL, 32'h0000_0000);
    check(rdVal, 32'h0000_0080);
    check(masterIrqGate, 1'b1);
    apb(1'b1, exec_pkg::REG_IRQCTL, 32'h0000_0000);
    apb(1'b1, exec_pkg::REG_FLAGS, 32'h0000_0001);
    $display("Test registers done");
    for (int i = 0; i < 9; i++)
    begin
      // Return addresses are stacked last pushed first, ahead of the return chain
      if (i == 6)
      begin
        apb(1'b1, exec_pkg::REG_STACK, 32'h0000_0040);
        apb(1'b1, exec_pkg::REG_STACK, 32'h0000_0030);
        apb(1'b1, exec_pkg::REG_STACK, 32'h0000_0020);
      end
      run(stopTab[i]);
      check(lastCyc, cycTab[i]);
      check(lowCyc, (i >= 6) ? 1 : 0);
      check(fetchAddr, stopTab[i]);
      check(accumulator, accTab[i]);
      check(zeroFlag, zeroTab[i]);
      check(masterIrqGate, gateTab[i]);
      $display("Test program stretch %0d done", i);
    end
    apb(1'b0, exec_pkg::REG_PC, 32'h0000_0000);
    check(rdVal, 32'h0000_0040);
    apb(1'b1, exec_pkg::REG_STACK, 32'h0000_0007);
    apb(1'b0, exec_pkg::REG_STACK, 32'h0000_0000);
    check(rdVal, 32'h0000_0007);
    run(65);
    check(lastCyc, 1);
    check(lowCyc, 0);
    check(accumulator, 8'h00);
    apb(1'b0, exec_pkg::REG_FLAGS, 32'h0000_0000);
    check(rdVal, 32'h0000_0004);
    apb(1'b1, exec_pkg::REG_FLAGS, 32'h0000_0004);
    apb(1'b0, exec_pkg::REG_FLAGS, 32'h0000_0000);
    check(rdVal, 32'h0000_0000);
    $display("Test unknown word and readback done");
    tally_and_finish;
  end
endmodule : tb_top
